// ### design/led_matrix_global_config_regs.sv
// Global identity, switching-enable and general configuration registers of the switch matrix.
// Assumes a serial front end on core_clk that issues single-cycle read and write strobes.
// Assumes duty values arrive on core_clk; only the CLK pin and reset are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module led_matrix_global_config_regs #(
	parameter int unsigned DIV_BASE = led_cfg_pkg::DIV_BASE_DEFAULT,
	parameter logic [4:0] REVISION_CODE = led_cfg_pkg::REVISION_CODE_DEFAULT
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic [71:0] duty_all,
	output logic [5:0] switch_closed,
	output logic switching_active,
	output logic [2:0] short_thresh_upper,
	output logic [2:0] short_thresh_lower,
	output logic [2:0] slew_code,
	output logic [1:0] div_code,
	output logic [1:0] clk_sel,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n
);

	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_int_n;

	logic enable_q;
	logic enable_d;
	logic [12:0] gen_cfg_q;
	logic [12:0] gen_cfg_d;

	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic rd_valid_q;
	logic rd_valid_d;
	logic [15:0] word_identity;
	logic [15:0] word_enable;
	logic [15:0] word_gen_cfg;

	logic [11:0] pwm_cnt_q;
	logic [11:0] pwm_cnt_d;
	logic [2:0] slew_q;
	logic [2:0] slew_d;
	logic [5:0] closed_q;
	logic [5:0] closed_d;

	logic wr_identity;
	logic wr_enable;
	logic wr_gen_cfg;
	logic period_end;

	dim_clk_if dim_bus ();

	// Reset is asserted at once but released only after two clean core edges.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_int_n = rst_sync_q;

	// Register writes: the decode is shared, each register keeps its own next-state logic.
	always_comb
	begin
		wr_identity = reg_wr_en && (reg_addr == led_cfg_pkg::ADDR_IDENTITY);
		wr_enable = reg_wr_en && (reg_addr == led_cfg_pkg::ADDR_SW_ENABLE);
		wr_gen_cfg = reg_wr_en && (reg_addr == led_cfg_pkg::ADDR_GEN_CFG);
	end

	// Only the enable bit is stored; the other bits of such a write are dropped.
	always_comb
	begin
		enable_d = enable_q;
		if (wr_enable)
		begin
			enable_d = reg_wdata[led_cfg_pkg::ENABLE_BIT];
		end
		// A write to the identity word changes nothing.
		if (wr_identity)
		begin
			enable_d = enable_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			enable_q <= led_cfg_pkg::ENABLE_RESET;
		end
		else
		begin
			enable_q <= enable_d;
		end
	end

	always_comb
	begin
		gen_cfg_d = gen_cfg_q;
		if (wr_gen_cfg)
		begin
			gen_cfg_d = reg_wdata[led_cfg_pkg::GEN_CFG_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			gen_cfg_q <= led_cfg_pkg::GEN_CFG_RESET;
		end
		else
		begin
			gen_cfg_q <= gen_cfg_d;
		end
	end

	// Each readable word is built in full so that reserved positions are zero by construction.
	always_comb
	begin
		word_identity = '0;
		word_identity[led_cfg_pkg::CHECK_LSB +: 5] = led_cfg_pkg::CHECK_PATTERN;
		word_identity[led_cfg_pkg::REV_LSB +: 5] = REVISION_CODE;
		word_enable = '0;
		word_enable[led_cfg_pkg::ENABLE_BIT] = enable_q;
		word_gen_cfg = '0;
		word_gen_cfg[led_cfg_pkg::GEN_CFG_W-1:0] = gen_cfg_q;
	end

	// Register reads answer one cycle after the strobe.
	always_comb
	begin
		rd_valid_d = reg_rd_en;
		rdata_d = rdata_q;
		if (reg_rd_en)
		begin
			rdata_d = '0;
			case (reg_addr)
				led_cfg_pkg::ADDR_IDENTITY:
				begin
					rdata_d = word_identity;
				end
				led_cfg_pkg::ADDR_SW_ENABLE:
				begin
					rdata_d = word_enable;
				end
				led_cfg_pkg::ADDR_GEN_CFG:
				begin
					rdata_d = word_gen_cfg;
				end
				default:
				begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// Read data holds its last value between reads; only the valid pulse marks a new one.
	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			rdata_q <= '0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// Dimming clock source, pin direction and divider.
	assign dim_bus.div_code = gen_cfg_q[led_cfg_pkg::DIV_LSB +: 2];
	assign dim_bus.clk_sel = led_cfg_pkg::clk_sel_t'(gen_cfg_q[led_cfg_pkg::CLKSEL_LSB +: 2]);

	dim_clock_gen #(
		.DIV_BASE(DIV_BASE)
	) u_dim_clock_gen (
		.core_clk(core_clk),
		.rst_int_n(rst_int_n),
		.cfg(dim_bus),
		.clk_pin_in(clk_pin_in),
		.clk_pin_out(clk_pin_out),
		.clk_pin_oe_n(clk_pin_oe_n)
	);

	// Dimming counter and the slew code that is applied to the gate drivers.
	always_comb
	begin
		period_end = dim_bus.pwm_tick && (pwm_cnt_q == led_cfg_pkg::PWM_CNT_MAX);
		pwm_cnt_d = pwm_cnt_q;
		slew_d = slew_q;
		if (!enable_q)
		begin
			pwm_cnt_d = led_cfg_pkg::PWM_CNT_ZERO;
		end
		else if (dim_bus.pwm_tick)
		begin
			// The counter wraps from its top value to zero, so every period has one length.
			pwm_cnt_d = pwm_cnt_q + 12'h001;
		end
		// A new slew code only takes effect at a period boundary so that a running
		// edge is never reshaped halfway; while idle it follows the register at once.
		if (!enable_q || period_end)
		begin
			slew_d = gen_cfg_d[led_cfg_pkg::SLEW_LSB +: 3];
		end
	end

	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			pwm_cnt_q <= led_cfg_pkg::PWM_CNT_ZERO;
			slew_q <= led_cfg_pkg::SLEW_RESET;
		end
		else
		begin
			pwm_cnt_q <= pwm_cnt_d;
			slew_q <= slew_d;
		end
	end

	// Each switch opens, lighting its LED, while the counter is below that switch's duty.
	genvar sw;
	generate
		for (sw = 0; sw < led_cfg_pkg::NUM_SWITCHES; sw++)
		begin : g_switch
			always_comb
			begin
				if (!enable_q)
				begin
					closed_d[sw] = 1'b1;
				end
				else
				begin
					closed_d[sw] = pwm_cnt_q >= duty_all[sw*led_cfg_pkg::DUTY_W +: 12];
				end
			end
		end
	endgenerate

	// Reset leaves every switch closed so that no LED flashes while the bank wakes up.
	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			closed_q <= '1;
		end
		else
		begin
			closed_q <= closed_d;
		end
	end

	// Configuration fields seen by the analogue side come straight from the register, except the slew code, which comes from slew_q.
	assign short_thresh_upper = gen_cfg_q[led_cfg_pkg::UPPER_LSB +: 3];
	assign short_thresh_lower = gen_cfg_q[led_cfg_pkg::LOWER_LSB +: 3];
	assign div_code = gen_cfg_q[led_cfg_pkg::DIV_LSB +: 2];
	assign clk_sel = gen_cfg_q[led_cfg_pkg::CLKSEL_LSB +: 2];
	assign slew_code = slew_q;
	assign switching_active = enable_q;
	assign switch_closed = closed_q;
	assign reg_rdata = rdata_q;
	assign reg_rd_valid = rd_valid_q;

endmodule : led_matrix_global_config_regs
`default_nettype wire

// ### pkg/led_cfg_pkg.sv
// Shared constants for the global identity, switching-enable and configuration registers.
// Assumes a 16-bit register word and an 8-bit register index from the serial front end.
package led_cfg_pkg;

	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 16;
	localparam int NUM_SWITCHES = 6;
	localparam int DUTY_W = 12;
	localparam int CODE_W = 3;
	localparam int DIV_CNT_W = 17;

	localparam logic [7:0] ADDR_IDENTITY = 8'h00;
	localparam logic [7:0] ADDR_SW_ENABLE = 8'h01;
	localparam logic [7:0] ADDR_GEN_CFG = 8'h02;

	// Identity word layout.
	localparam logic [4:0] CHECK_PATTERN = 5'h11;
	localparam int CHECK_LSB = 0;
	localparam int REV_LSB = 8;
	// Revision code value is arbitrary.
	localparam logic [4:0] REVISION_CODE_DEFAULT = 5'h01;

	// Switching-enable register layout.
	localparam int ENABLE_BIT = 0;
	localparam logic ENABLE_RESET = 1'b0;

	// General configuration layout.
	localparam int UPPER_LSB = 10;
	localparam int LOWER_LSB = 7;
	localparam int SLEW_LSB = 4;
	localparam int DIV_LSB = 2;
	localparam int CLKSEL_LSB = 0;
	localparam int GEN_CFG_W = 13;
	localparam logic [12:0] GEN_CFG_RESET = 13'h0000;

	localparam logic [2:0] SLEW_RESET = 3'h0;
	localparam logic [11:0] PWM_CNT_MAX = 12'hFFF;
	localparam logic [11:0] PWM_CNT_ZERO = 12'h000;

	// Smallest dimming divide ratio; each step of the divider code doubles it.
	localparam int unsigned DIV_BASE_DEFAULT = 8192;

	typedef enum logic [1:0]
	{
		CLK_INT_PIN_OFF,
		CLK_INT_PIN_OUT,
		CLK_EXT_LOW,
		CLK_EXT_HIGH
	} clk_sel_t;

endpackage : led_cfg_pkg

// ### pkg/dim_clk_if.sv
// Carrier between the register bank and the dimming clock generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface dim_clk_if;
	logic [1:0] div_code;
	led_cfg_pkg::clk_sel_t clk_sel;
	logic pwm_tick;

	modport gen (input div_code, input clk_sel, output pwm_tick);
	modport ctl (output div_code, output clk_sel, input pwm_tick);
endinterface : dim_clk_if
`default_nettype wire

// ### design/dim_clock_gen.sv
// Dimming clock generator: source select, CLK pin handling and the dimming divider.
// Assumes the reset input is already synchronised to core_clk.
`timescale 1ns/1ns
`default_nettype none
module dim_clock_gen #(
	parameter int unsigned DIV_BASE = led_cfg_pkg::DIV_BASE_DEFAULT
)
(
	input wire logic core_clk,
	input wire logic rst_int_n,
	dim_clk_if.gen cfg,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n
);

	logic pin_meta_q, pin_sync_q, pin_last_q;
	logic pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d;
	logic [16:0] div_cnt_q, div_cnt_d, ratio;
	logic tick_q, tick_d, osc_en;

	// The external clock is only sampled, so it must stay well below half the core rate.
	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_last_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= clk_pin_in;
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end

	always_comb
	begin
		ratio = 17'(DIV_BASE << cfg.div_code);
		osc_en = 1'b1;
		pin_out_d = 1'b0;
		pin_oe_n_d = 1'b1;
		case (cfg.clk_sel)
			led_cfg_pkg::CLK_INT_PIN_OFF: osc_en = 1'b1;
			led_cfg_pkg::CLK_INT_PIN_OUT:
			begin
				pin_out_d = ~pin_out_q;
				pin_oe_n_d = 1'b0;
			end
			led_cfg_pkg::CLK_EXT_LOW,
			led_cfg_pkg::CLK_EXT_HIGH: osc_en = pin_sync_q & ~pin_last_q;
			default: osc_en = 1'b1;
		endcase
		div_cnt_d = div_cnt_q;
		tick_d = 1'b0;
		if (osc_en)
		begin
			if (div_cnt_q >= ratio - 17'h00001)
			begin
				div_cnt_d = '0;
				tick_d = 1'b1;
			end
			else
			begin
				div_cnt_d = div_cnt_q + 17'h00001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			div_cnt_q <= '0;
			tick_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_n_q <= 1'b1;
		end
		else
		begin
			div_cnt_q <= div_cnt_d;
			tick_q <= tick_d;
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	assign cfg.pwm_tick = tick_q;
	assign clk_pin_out = pin_out_q;
	assign clk_pin_oe_n = pin_oe_n_q;

endmodule : dim_clock_gen
`default_nettype wire

// ### test/host_model.sv
// Host side of the register port, issuing single-cycle read and write strobes.
// Assumes the bank samples its strobes on the rising edge of core_clk.
`timescale 1ns/1ns
`default_nettype none
module host_model
(
	input wire logic core_clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rd_valid
);
	initial
	begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'hA5;
		reg_wdata = 16'h5A5A;
	end

	// Idle address and data are inverted so that late sampling shows up as garbage.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge core_clk);
		#1;
		reg_wr_en = wr;
		reg_rd_en = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		q = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hDEAD;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// ### test/led_cfg_sva.sv
// Port checker for the global register bank.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/1ns
`default_nettype none
module led_cfg_sva #(
	parameter int unsigned DIV_BASE = 8192,
	parameter logic [4:0] REVISION_CODE = 5'h01
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic [71:0] duty_all,
	input wire logic [5:0] switch_closed,
	input wire logic switching_active,
	input wire logic [2:0] short_thresh_upper,
	input wire logic [2:0] short_thresh_lower,
	input wire logic [2:0] slew_code,
	input wire logic [1:0] div_code,
	input wire logic [1:0] clk_sel,
	input wire logic clk_pin_out,
	input wire logic clk_pin_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [5:0] duty_zero;

	always_comb
	begin
		for (int i = 0; i < 6; i++)
			duty_zero[i] = (duty_all[12*i +: 12] == 12'h000);
	end

	id_read_a: assert property (reg_rd_en && reg_addr == 8'h00 |=> reg_rd_valid &&
		reg_rdata == {3'h0, REVISION_CODE, 3'h0, 5'h11}) else $error("identity word wrong");
	en_write_a: assert property (reg_wr_en && reg_addr == 8'h01 |=>
		switching_active == $past(reg_wdata[0])) else $error("enable bit wrong");
	off_closed_a: assert property (!switching_active |=> switch_closed == 6'h3F)
		else $error("switch open while disabled");
	start_open_a: assert property ($rose(switching_active) |=>
		switch_closed == $past(duty_zero)) else $error("bad first switch state");
	cfg_fields_a: assert property (reg_wr_en && reg_addr == 8'h02 |=>
		{short_thresh_upper, short_thresh_lower, div_code, clk_sel} ==
		{$past(reg_wdata[12:7]), $past(reg_wdata[3:0])}) else $error("config field wrong");
	slew_idle_a: assert property (reg_wr_en && reg_addr == 8'h02 && !switching_active |=>
		slew_code == $past(reg_wdata[6:4])) else $error("slew code wrong");
	pin_drive_a: assert property (clk_sel == 2'h1 [*3] |-> !clk_pin_oe_n &&
		clk_pin_out != $past(clk_pin_out)) else $error("clock pin not driven");
	pin_idle_a: assert property (clk_sel != 2'h1 [*3] |-> clk_pin_oe_n && !clk_pin_out)
		else $error("clock pin driven");
	enable_rsvd_a: assert property (reg_rd_en && reg_addr == 8'h01 |=>
		reg_rdata[15:1] == 15'h0000) else $error("reserved bit set");
	unmapped_a: assert property (reg_rd_en && reg_addr > 8'h02 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule : led_cfg_sva

bind led_matrix_global_config_regs led_cfg_sva #(.DIV_BASE(DIV_BASE),
	.REVISION_CODE(REVISION_CODE)) led_cfg_sva_i (.core_clk, .rst_n, .reg_wr_en, .reg_rd_en,
	.reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .duty_all, .switch_closed,
	.switching_active, .short_thresh_upper, .short_thresh_lower, .slew_code, .div_code,
	.clk_sel, .clk_pin_out, .clk_pin_oe_n);
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the global register bank.
// Assumes a divider base of 4 so that dimming ticks come every few core cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic core_clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, switching_active;
	logic ext_lvl, clk_pin, clk_pin_out, clk_pin_oe_n;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q;
	logic [71:0] duty_all;
	logic [5:0] switch_closed;
	logic [2:0] short_thresh_upper, short_thresh_lower, slew_code;
	logic [1:0] div_code, clk_sel;
	int n_mismatch, n_checks;

	// The pin level follows the bank while it drives, else the external source.
	assign clk_pin = clk_pin_oe_n ? ext_lvl : clk_pin_out;

	led_matrix_global_config_regs #(.DIV_BASE(4)) led_matrix_global_config_regs_i (.core_clk,
		.rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
		.duty_all, .switch_closed, .switching_active, .short_thresh_upper,
		.short_thresh_lower, .slew_code, .div_code, .clk_sel, .clk_pin_in(clk_pin),
		.clk_pin_out, .clk_pin_oe_n);
	host_model host_model_i (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rd_valid);

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// External clock of six core cycles, left running so idle sampling is not flattered.
	initial
	begin
		ext_lvl = 1'b0;
		forever
		begin
			repeat (3) @(posedge core_clk);
			#1 ext_lvl = ~ext_lvl;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic t_regs();
		host_model_i.xfer(1'b0, 8'h00, 16'h0000, q);
		chk(q, 16'h0111);
		host_model_i.xfer(1'b1, 8'h00, 16'hFFFF, q);
		host_model_i.xfer(1'b0, 8'h00, 16'h0000, q);
		chk(q, 16'h0111);
		host_model_i.xfer(1'b1, 8'h07, 16'hFFFF, q);
		host_model_i.xfer(1'b0, 8'h07, 16'h0000, q);
		chk(q, 16'h0000);
		host_model_i.xfer(1'b1, 8'h01, 16'hFFFE, q);
		host_model_i.xfer(1'b0, 8'h01, 16'h0000, q);
		chk(q, 16'h0000);
		chk({10'h000, switch_closed}, 16'h003F);
	endtask : t_regs

	task automatic t_cfg();
		logic [15:0] w;
		for (int c = 0; c < 8; c++)
		begin
			// Slew is rewritten here only while switching is off.
			w = {3'h7, 3'(c), ~3'(c), 3'(c), 2'(c), 2'(c)};
			host_model_i.xfer(1'b1, 8'h02, w, q);
			chk({3'h0, short_thresh_upper, short_thresh_lower, slew_code, div_code, clk_sel},
				{3'h0, w[12:0]});
			host_model_i.xfer(1'b0, 8'h02, 16'h0000, q);
			chk(q, {3'h0, w[12:0]});
			chk({15'h0000, clk_pin_oe_n}, {15'h0000, w[1:0] != 2'h1});
		end
	endtask : t_cfg

	// Two switches close two ticks apart, which is free of the divider's start phase.
	task automatic t_div(input logic [1:0] d, input logic ext);
		int t;
		duty_all = {48'h0, 12'h003, 12'h001};
		// Slew is set before enabling, together with the divider code and clock source.
		host_model_i.xfer(1'b1, 8'h02, {10'h000, 2'h3, d, ext, ext}, q);
		host_model_i.xfer(1'b1, 8'h01, 16'h0001, q);
		@(posedge core_clk);
		#1;
		chk({9'h000, switching_active, switch_closed}, 16'h007C);
		t = 0;
		while (switch_closed[0] !== 1'b1 && t < 5000)
		begin
			@(posedge core_clk);
			#1;
			t++;
		end
		t = 0;
		while (switch_closed[1] !== 1'b1 && t < 5000)
		begin
			@(posedge core_clk);
			#1;
			t++;
		end
		chk(16'(t), ext ? 16'h0030 : 16'(8 << d));
		host_model_i.xfer(1'b1, 8'h01, 16'h0000, q);
		@(posedge core_clk);
		#1;
		chk({9'h000, switching_active, switch_closed}, 16'h003F);
	endtask : t_div

	initial
	begin
		rst_n = 1'b0;
		duty_all = '0;
		n_mismatch = 0;
		n_checks = 0;
		repeat (5) @(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs();
		t_cfg();
		for (int d = 0; d < 4; d++)
			t_div(2'(d), 1'b0);
		t_div(2'h0, 1'b1);
		print_verdict();
	end

	initial
	begin
		#800000;
		n_mismatch++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
